// ===== rtl/fdc_cmd_defs.svh
// command codes, status codes and timing constants for the seek/sense/set-track block
`ifndef FDC_CMD_DEFS_SVH
`define FDC_CMD_DEFS_SVH
`define CLK_NS          40
`define HALF_MS_NS      500000
`define STEP_PULSE_NS   4000
`define OP_SEEK         8'h0f
`define OP_SENSE_DRV    8'h04
`define OP_SENSE_INT    8'h08
`define OP_STRK_MASK    8'hbf
`define OP_STRK         8'h21
`define OP_SCAN_LE      5'h19
`define STRK_WNR_BIT    6
`define LEN_SEEK        4'h3
`define LEN_SEEK_ETR    4'h4
`define LEN_SENSE_DRV   4'h2
`define LEN_SENSE_INT   4'h1
`define LEN_STRK        4'h3
`define LEN_SCAN        4'h9
`define LEN_INVALID     4'h1
`define RES_ONE         2'h1
`define RES_TWO         2'h2
`define RES_THREE       2'h3
`define ST0_INVALID     8'h80
`define CAUSE_READY     3'h6
`define CAUSE_SEEK_OK   3'h1
`define ST2_SCAN_EQ     3
`define ST2_SCAN_NOMET  2
`define RATE_500K       2'h0
`define RATE_300K       2'h1
`define RATE_250K       2'h2
`define RATE_1M         2'h3
`define SRT_BASE        5'h10
`define MNT_ZERO        8'h80
`endif

// ===== rtl/fdc_cmd_pkg.sv
// state types for the seek/sense/set-track block
package fdc_cmd_pkg;
	typedef enum logic [1:0] {
		C_IDLE   = 2'b00,
		C_PARAM  = 2'b01,
		C_SCAN   = 2'b10,
		C_RESULT = 2'b11
	} cmd_state_t;
	typedef enum logic [1:0] {
		K_IDLE  = 2'b00,
		K_MOTOR = 2'b01,
		K_STEP  = 2'b10
	} seek_state_t;
endpackage : fdc_cmd_pkg

// ===== rtl/halfms_timer.sv
// restartable delay timer counting in half-millisecond units
`timescale 1ns/1ps
`default_nettype none
module halfms_timer #(
	parameter int HALF_MS_CYCLES = 12500
) (
	input  wire logic        clk_sys,  // system clock
	input  wire logic        rst,      // sync reset
	input  wire logic        load,     // restart with new length
	input  wire logic [11:0] units,    // length in half-ms units, not zero
	output logic             expire,   // one-cycle pulse at the end
	output logic             running   // delay in progress
);
	logic [15:0] pre;
	logic [11:0] left;
	logic        unit_end;

	// prescaler restarts on load so each delay is exact
	assign unit_end = running && (pre == 16'(HALF_MS_CYCLES - 1));
	// end flagged in the last cycle so a reload keeps the period exact
	assign expire   = unit_end && (left == 12'h001);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pre     <= 16'h0000;
			left    <= 12'h000;
			running <= 1'h0;
		end else if (load) begin
			pre     <= 16'h0000;
			left    <= units;
			running <= 1'h1;
		end else if (unit_end) begin
			pre     <= 16'h0000;
			left    <= left - 12'h001;
			running <= (left != 12'h001);
		end else begin
			pre <= running ? pre + 16'h0001 : pre;
		end
	end
endmodule : halfms_timer
`default_nettype wire

// ===== rtl/fdc_seek_sense_settrack_cmds.sv
// command interpreter for scan-low-or-equal, seek, sense and set-track commands
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cmd_defs.svh"

module fdc_seek_sense_settrack_cmds
	import fdc_cmd_pkg::*;
#(
	parameter int HALF_MS_CYCLES = `HALF_MS_NS / `CLK_NS
) (
	input  wire logic       clk_sys,              // 25 MHz clock
	input  wire logic       rst,                  // sync reset, active high
	input  wire logic       soft_reset,           // software reset pulse
	input  wire logic       wr_strobe,            // host writes data register
	input  wire logic [7:0] wr_data,              // byte written
	input  wire logic       rd_strobe,            // host reads data register
	input  wire logic [3:0] step_rate_field,      // step rate setting
	input  wire logic [6:0] motor_on_field,       // motor-on delay setting
	input  wire logic [1:0] data_rate,            // data rate code
	input  wire logic       extended_track_range, // 12-bit track mode
	input  wire logic       wildcard_mode,        // ff bytes always match
	input  wire logic       result_entry,         // other command entered result
	input  wire logic       nondma_xfer,          // non-dma transfer event
	input  wire logic [7:0] disk_byte,            // byte read from disk
	input  wire logic       disk_valid,           // disk byte present
	input  wire logic       scan_end,             // scan sectors done
	input  wire logic [3:0] drive_ready_pin,      // ready per drive
	input  wire logic       write_protect_pin,    // selected drive protected
	input  wire logic       track0_pin,           // head at track 0
	input  wire logic       two_side_pin,         // drive is two-sided
	output logic      [7:0] rd_data,              // current result byte
	output logic            result_valid,         // result byte waiting
	output logic            cmd_busy,             // command in progress
	output logic      [3:0] drive_seek_busy,      // seek running per drive
	output logic            step_pulse,           // step to drive
	output logic            step_dir,             // 1 toward higher tracks
	output logic            int_req,              // interrupt to host
	output logic      [7:0] scan_status,          // status two scan bits
	output logic            scan_byte_req         // scan wants a host byte
);
	localparam int STEP_W = (`STEP_PULSE_NS + `CLK_NS - 1) / `CLK_NS;

	logic              rst_any;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst_any);
	logic [6:0]        pin_meta, pin_sync;
	logic [3:0]        ready_prev;
	cmd_state_t        state;
	seek_state_t       seek_state;
	logic [7:0]        op, arg1, arg2, arg3, res1, res2;
	logic [3:0]        byte_idx, need_len;
	logic [1:0]        res_left;
	logic [3:0][15:0]  ptr;
	logic [3:0]        seek_pend, ready_pend, seek_head;
	logic              ready_armed, auto_int, svc_live, svc_seek_q;
	logic [1:0]        svc_drv_q, seek_drv;
	logic [11:0]       seek_target, seek_steps;
	logic [7:0]        step_cnt;
	logic              tmr_expire, host_have, scan_decided, scan_gt;
	logic [7:0]        host_byte;

	///////////////////////////////////////////////////////////////////////
	// pin synchronisers
	assign rst_any = rst | soft_reset;

	always_ff @(posedge clk_sys) begin
		pin_meta <= {two_side_pin, track0_pin, write_protect_pin, drive_ready_pin};
		pin_sync <= pin_meta;
	end

	///////////////////////////////////////////////////////////////////////
	// command decode
	logic [7:0] op_sel, a1, a2, a3;
	logic       is_seek, is_sdrv, is_sint, is_strk, is_scan, byte_take, last_byte;
	assign op_sel    = (state == C_IDLE) ? wr_data : op;
	assign is_seek   = (op_sel == `OP_SEEK);
	assign is_sdrv   = (op_sel == `OP_SENSE_DRV);
	assign is_sint   = (op_sel == `OP_SENSE_INT);
	assign is_strk   = ((op_sel & `OP_STRK_MASK) == `OP_STRK);
	assign is_scan   = (op_sel[4:0] == `OP_SCAN_LE);
	assign need_len  = is_seek ? (extended_track_range ? `LEN_SEEK_ETR : `LEN_SEEK) :
		is_sdrv ? `LEN_SENSE_DRV : is_sint ? `LEN_SENSE_INT :
		is_strk ? `LEN_STRK : is_scan ? `LEN_SCAN : `LEN_INVALID;
	assign byte_take = wr_strobe && (state == C_IDLE || state == C_PARAM);
	assign last_byte = byte_take && (byte_idx + 4'h1 == need_len);
	assign a1        = (byte_idx == 4'h1) ? wr_data : arg1;
	assign a2        = (byte_idx == 4'h2) ? wr_data : arg2;
	assign a3        = (byte_idx == 4'h3) ? wr_data : arg3;

	///////////////////////////////////////////////////////////////////////
	// pending interrupt selection, seek ahead of ready
	logic [1:0] svc_drv;
	logic       svc_seek, any_pend;
	always_comb begin
		svc_drv  = 2'h0;
		svc_seek = 1'h0;
		for (int i = 3; i >= 0; i--) begin
			if (ready_pend[i]) begin
				svc_drv = 2'(i);
			end
		end
		for (int i = 3; i >= 0; i--) begin
			if (seek_pend[i]) begin
				svc_drv  = 2'(i);
				svc_seek = 1'h1;
			end
		end
	end
	assign any_pend = (|seek_pend) | (|ready_pend);

	///////////////////////////////////////////////////////////////////////
	// result bytes for the sense, set-track and invalid commands
	logic [7:0]  st0, st3, trk_byte;
	logic [1:0]  trk_drv;
	logic [15:0] svc_ptr;
	logic [7:0]  r0, r1, r2;
	logic [1:0]  rcnt;
	assign st0      = svc_seek ? {`CAUSE_SEEK_OK, 2'h0, seek_head[svc_drv], svc_drv}
		: {`CAUSE_READY, 3'h0, svc_drv};
	assign st3      = {1'h0, pin_sync[4], pin_sync[a1[1:0]], pin_sync[5], pin_sync[6], a1[2:0]};
	assign trk_drv  = a1[1:0];
	assign trk_byte = op_sel[`STRK_WNR_BIT] ? a2
		: (a1[2] ? ptr[trk_drv][15:8] : ptr[trk_drv][7:0]);
	assign svc_ptr  = ptr[svc_drv];
	assign r0       = is_sdrv ? st3 : is_strk ? trk_byte
		: (is_sint && any_pend) ? st0 : `ST0_INVALID;
	assign r1       = svc_ptr[7:0];
	assign r2       = {svc_ptr[11:8], 4'h0};
	assign rcnt     = (is_sint && any_pend) ? (extended_track_range ? `RES_THREE : `RES_TWO) : `RES_ONE;

	///////////////////////////////////////////////////////////////////////
	// seek setup and step timing
	logic [11:0] seek_cur, seek_tgt_w, motor_units, step_units, tmr_units;
	logic [4:0]  srt_n;
	logic [7:0]  mnt_n;
	logic        seek_start, step_go, seek_finish, tmr_load;
	assign seek_start  = last_byte && is_seek;
	assign seek_cur    = ptr[a1[1:0]][11:0];
	assign seek_tgt_w  = extended_track_range ? {a3[7:4], a2} : {4'h0, a2};
	assign srt_n       = `SRT_BASE - {1'h0, step_rate_field};
	assign step_units  = (data_rate == `RATE_1M) ? {7'h00, srt_n}
		: (data_rate == `RATE_500K) ? {6'h00, srt_n, 1'h0}
		: (data_rate == `RATE_250K) ? {5'h00, srt_n, 2'h0}
		: 12'(({7'h00, srt_n} * 12'h00a) / 12'h003);
	assign mnt_n       = (motor_on_field == 7'h00) ? `MNT_ZERO : {1'h0, motor_on_field};
	assign motor_units = (data_rate == `RATE_250K) ? {1'h0, mnt_n, 3'h0}
		: (data_rate == `RATE_300K) ? 12'(({4'h0, mnt_n} * 12'h014) / 12'h003)
		: {3'h0, mnt_n, 1'h0};
	assign step_go     = tmr_expire && seek_state != K_IDLE && seek_steps != 12'h000;
	assign seek_finish = tmr_expire && seek_state != K_IDLE && seek_steps == 12'h000;
	assign tmr_load    = seek_start || step_go;
	assign tmr_units   = seek_start ? motor_units : step_units;

	halfms_timer #(
		.HALF_MS_CYCLES(HALF_MS_CYCLES)
	) u_timer (
		.clk_sys (clk_sys),
		.rst     (rst_any),
		.load    (tmr_load),
		.units   (tmr_units),
		.expire  (tmr_expire),
		.running ()
	);

	// seek engine: one seek at a time, host keeps others off
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			seek_state      <= K_IDLE;
			drive_seek_busy <= 4'h0;
			step_dir        <= 1'h0;
			seek_steps      <= 12'h000;
			seek_target     <= 12'h000;
			seek_drv        <= 2'h0;
			seek_head       <= 4'h0;
		end else begin
			unique case (seek_state)
				K_IDLE: begin
					if (seek_start) begin
						seek_state       <= K_MOTOR;
						seek_drv         <= a1[1:0];
						seek_head[a1[1:0]] <= a1[2];
						seek_target      <= seek_tgt_w;
						step_dir         <= (seek_tgt_w > seek_cur);
						seek_steps       <= (seek_tgt_w > seek_cur) ? seek_tgt_w - seek_cur : seek_cur - seek_tgt_w;
						drive_seek_busy[a1[1:0]] <= 1'h1;
					end
				end
				K_MOTOR, K_STEP: begin
					if (step_go) begin
						seek_state <= K_STEP;
						seek_steps <= seek_steps - 12'h001;
					end else if (seek_finish) begin
						seek_state <= K_IDLE;
						drive_seek_busy[seek_drv] <= 1'h0;
					end
				end
				default: seek_state <= K_IDLE;
			endcase
		end
	end

	// step pulse width
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			step_cnt   <= 8'h00;
			step_pulse <= 1'h0;
		end else begin
			step_cnt   <= step_go ? 8'(STEP_W) : step_cnt - {7'h00, step_cnt != 8'h00};
			step_pulse <= step_go || step_cnt > 8'h01;
		end
	end

	///////////////////////////////////////////////////////////////////////
	// present track registers
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			ptr <= '0;
		end else if (seek_finish) begin
			ptr[seek_drv] <= {4'h0, seek_target};
		end else if (last_byte && is_strk && op_sel[`STRK_WNR_BIT]) begin
			if (a1[2]) begin
				ptr[trk_drv][15:8] <= a2;
			end else begin
				ptr[trk_drv][7:0] <= a2;
			end
		end
	end

	///////////////////////////////////////////////////////////////////////
	// interrupt causes; a new event wins over a clear in the same cycle
	logic       rd_take, svc_clear;
	logic       scan_pair, scan_fin, scan_match;
	logic [3:0] ready_chg, seek_set, clr_mask;
	assign rd_take   = rd_strobe && state == C_RESULT;
	assign svc_clear = rd_take && svc_live;
	assign clr_mask  = 4'h1 << svc_drv_q;
	assign seek_set  = seek_finish ? (4'h1 << seek_drv) : 4'h0;
	assign ready_chg = (pin_sync[3:0] ^ ready_prev) & {4{ready_armed}};

	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			ready_prev  <= 4'h0;
			ready_armed <= 1'h1;
			seek_pend   <= 4'h0;
			ready_pend  <= 4'h0;
			auto_int    <= 1'h0;
			int_req     <= 1'h0;
		end else begin
			ready_prev  <= pin_sync[3:0];
			ready_armed <= ready_armed && !(last_byte && !is_sint);
			seek_pend   <= (seek_pend & ~(svc_clear && svc_seek_q ? clr_mask : 4'h0)) | seek_set;
			ready_pend  <= (ready_pend & ~(svc_clear && !svc_seek_q ? clr_mask : 4'h0)) | ready_chg;
			auto_int    <= result_entry || nondma_xfer || scan_fin
				|| (auto_int && !(rd_strobe || wr_strobe));
			int_req     <= auto_int || any_pend;
		end
	end

	///////////////////////////////////////////////////////////////////////
	// scan-low-or-equal comparison, most significant byte first
	assign scan_pair  = state == C_SCAN && host_have && disk_valid;
	assign scan_fin   = state == C_SCAN && scan_end;
	assign scan_match = (disk_byte == host_byte)
		|| (wildcard_mode && (disk_byte == 8'hff || host_byte == 8'hff));

	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			host_have     <= 1'h0;
			host_byte     <= 8'h00;
			scan_decided  <= 1'h0;
			scan_gt       <= 1'h0;
			scan_status   <= 8'h00;
			scan_byte_req <= 1'h0;
		end else begin
			if (last_byte && is_scan) begin
				scan_decided <= 1'h0;
				scan_gt      <= 1'h0;
			end else if (scan_pair && !scan_match && !scan_decided) begin
				scan_decided <= 1'h1;
				scan_gt      <= disk_byte > host_byte;
			end
			if (state == C_SCAN && wr_strobe) begin
				host_have <= 1'h1;
				host_byte <= wr_data;
			end else if (scan_pair || scan_fin) begin
				host_have <= 1'h0;
			end
			if (scan_fin) begin
				scan_status[`ST2_SCAN_EQ]    <= !scan_decided;
				scan_status[`ST2_SCAN_NOMET] <= scan_decided && scan_gt;
			end
			scan_byte_req <= state == C_SCAN && !host_have && !scan_fin && !(wr_strobe || scan_pair);
		end
	end

	///////////////////////////////////////////////////////////////////////
	// command and result phases
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			state        <= C_IDLE;
			byte_idx     <= 4'h0;
			op           <= 8'h00;
			arg1         <= 8'h00;
			arg2         <= 8'h00;
			arg3         <= 8'h00;
			cmd_busy     <= 1'h0;
		end else begin
			if (byte_take) begin
				byte_idx <= last_byte ? 4'h0 : byte_idx + 4'h1;
				if (byte_idx == 4'h0) op   <= wr_data;
				if (byte_idx == 4'h1) arg1 <= wr_data;
				if (byte_idx == 4'h2) arg2 <= wr_data;
				if (byte_idx == 4'h3) arg3 <= wr_data;
			end
			unique case (state)
				C_IDLE, C_PARAM: begin
					if (last_byte) begin
						state    <= is_seek ? C_IDLE : is_scan ? C_SCAN : C_RESULT;
						cmd_busy <= !is_seek;
					end else if (byte_take) begin
						state    <= C_PARAM;
						cmd_busy <= 1'h1;
					end
				end
				C_SCAN: begin
					if (scan_fin) begin
						state    <= C_IDLE;
						cmd_busy <= 1'h0;
					end
				end
				C_RESULT: begin
					if (rd_take && res_left == `RES_ONE) begin
						state    <= C_IDLE;
						cmd_busy <= 1'h0;
					end
				end
			endcase
		end
	end

	// result byte queue
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			rd_data      <= 8'h00;
			res1         <= 8'h00;
			res2         <= 8'h00;
			res_left     <= 2'h0;
			result_valid <= 1'h0;
			svc_live     <= 1'h0;
			svc_seek_q   <= 1'h0;
			svc_drv_q    <= 2'h0;
		end else if (last_byte && !is_seek && !is_scan) begin
			rd_data      <= r0;
			res1         <= r1;
			res2         <= r2;
			res_left     <= rcnt;
			result_valid <= 1'h1;
			svc_live     <= is_sint && any_pend;
			svc_seek_q   <= svc_seek;
			svc_drv_q    <= svc_drv;
		end else if (rd_take) begin
			rd_data      <= res1;
			res1         <= res2;
			res_left     <= res_left - 2'h1;
			result_valid <= res_left != `RES_ONE;
			svc_live     <= 1'h0;
		end
	end

	///////////////////////////////////////////////////////////////////////
	// checks
	seek_busy_a: assert property (seek_start |=> drive_seek_busy[$past(a1[1:0])])
		else $error("seek did not mark drive busy");
	seek_nores_a: assert property (seek_start |=> !result_valid && state == C_IDLE)
		else $error("seek produced a result phase");
	seek_dir_a: assert property (seek_start && seek_tgt_w > seek_cur |=> step_dir)
		else $error("direction wrong for inward seek");
	step_after_a: assert property ($rose(step_pulse) |-> $past(tmr_expire) && seek_state == K_STEP)
		else $error("step pulse without elapsed delay");
	step_rate_a: assert property (step_go && data_rate == `RATE_1M |-> tmr_units == 12'(16 - int'(step_rate_field)))
		else $error("step interval wrong at 1 Mbps");
	seek_int_a: assert property (seek_finish |-> ##2 int_req)
		else $error("no interrupt after seek end");
	pend_hold_a: assert property (|seek_pend && !svc_clear |=> |seek_pend)
		else $error("seek interrupt cleared without sense");
	sint_inval_a: assert property (last_byte && is_sint && !any_pend |=> rd_data == `ST0_INVALID)
		else $error("sense interrupt not invalid when idle");
	sdrv_one_a: assert property (last_byte && is_sdrv |=> result_valid && res_left == `RES_ONE)
		else $error("sense drive status length wrong");
	auto_clr_a: assert property (rd_strobe && !result_entry && !nondma_xfer && !scan_fin |=> !auto_int)
		else $error("auto interrupt not cleared by access");
	res_done_a: assert property (rd_take && res_left == `RES_ONE |=> !cmd_busy && !result_valid)
		else $error("busy held after last result");
	seek_end_c: cover property (seek_finish);
	sint_seek_c: cover property (last_byte && is_sint && svc_seek);
	strk_wr_c: cover property (last_byte && is_strk && op_sel[`STRK_WNR_BIT]);
	scan_fin_c: cover property (scan_fin && scan_decided);
endmodule : fdc_seek_sense_settrack_cmds
`default_nettype wire

// ===== bench/fdc_drive_model.sv
// floppy drive model: head position, track zero and status pins
`timescale 1ns/1ps
`default_nettype none
module drive_model (
	input  wire logic       clk_sys,           // system clock
	input  wire logic       step_pulse,        // step from controller
	input  wire logic       step_dir,          // 1 toward higher tracks
	input  wire logic [3:0] ready_cmd,         // ready per drive from bench
	output logic      [3:0] drive_ready_pin,   // ready per drive
	output logic            write_protect_pin, // media protected
	output logic            track0_pin,        // head at track 0
	output logic            two_side_pin       // two-sided drive
);
	int   pos       = 0;
	logic last_step = 1'b0;
	// head moves one track per rising step edge, way set by direction
	always @(posedge clk_sys) begin
		last_step <= step_pulse;
		if (step_pulse && !last_step) pos <= step_dir ? pos + 1 : pos - 1;
	end
	assign drive_ready_pin   = ready_cmd;
	assign write_protect_pin = 1'b1;
	assign track0_pin        = (pos == 0);
	assign two_side_pin      = 1'b1;
endmodule : drive_model
`default_nettype wire

// ===== bench/fdc_seek_sense_settrack_cmds_test.sv
// self-checking bench for the seek, sense and set-track command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module fdc_seek_sense_settrack_cmds_test;
	logic       clk_sys = 0, rst = 1, soft_reset = 0, wr_strobe = 0, rd_strobe = 0, scan_end = 0;
	logic       extended_track_range = 0, result_entry = 0, nondma_xfer = 0, disk_valid = 0;
	logic [7:0] wr_data = 0, disk_byte = 0, rd_data, scan_status;
	logic [1:0] data_rate = 0;
	logic [3:0] ready_cmd = 0, drive_ready_pin, drive_seek_busy;
	logic       write_protect_pin, track0_pin, two_side_pin, result_valid, cmd_busy, step_pulse, step_dir;
	logic       int_req, scan_byte_req;
	int         fail_count = 0, n_checks = 0, n;

	fdc_seek_sense_settrack_cmds #(.HALF_MS_CYCLES(20)) dut_u (.clk_sys, .rst, .soft_reset, .wr_strobe,
		.wr_data, .rd_strobe, .step_rate_field(4'h8), .motor_on_field(7'h01), .data_rate, .extended_track_range,
		.wildcard_mode(1'b0), .result_entry, .nondma_xfer, .disk_byte, .disk_valid, .scan_end, .drive_ready_pin,
		.write_protect_pin, .track0_pin, .two_side_pin, .rd_data, .result_valid, .cmd_busy, .drive_seek_busy,
		.step_pulse, .step_dir, .int_req, .scan_status, .scan_byte_req);
	drive_model dm_u (.clk_sys, .step_pulse, .step_dir, .ready_cmd, .drive_ready_pin, .write_protect_pin,
		.track0_pin, .two_side_pin);

	// 25 MHz clock
	initial forever #20 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	// wait k edges, then step just past the edge
	task automatic tick(int k = 1);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic wr(logic [7:0] b);
		tick();
		wr_strobe = 1;
		wr_data   = b;
		tick();
		wr_strobe = 0;
	endtask : wr

	task automatic cmd(logic [7:0] a, b);
		wr(a);
		wr(b);
	endtask : cmd

	// wait for a result byte, compare it and consume it
	task automatic rd(logic [7:0] e);
		n = 0;
		while (result_valid !== 1'b1 && n < 50) begin tick(); n++; end
		`CHK(rd_data, e)
		rd_strobe = 1;
		tick();
		rd_strobe = 0;
		tick();
	endtask : rd

	task automatic pulse_rd();
		rd_strobe = 1;
		tick();
		rd_strobe = 0;
		tick(2);
	endtask : pulse_rd

	// cycles from now (or the last rise) to the next step rise
	task automatic wait_rise();
		n = 0;
		while (step_pulse === 1'b1 && n < 5000) begin tick(); n++; end
		while (step_pulse !== 1'b1 && n < 5000) begin tick(); n++; end
	endtask : wait_rise

	// seek, time its steps, then only sense interrupt until done
	task automatic seek(logic [7:0] b2, logic [11:0] t, logic [1:0] rate, int steps, int ival, int motor);
		int p0;
		p0        = dm_u.pos;
		data_rate = rate;
		cmd(8'h0f, b2);
		wr(t[7:0]);
		if (extended_track_range) wr({t[11:8], 4'h0});
		tick();
		`CHK(drive_seek_busy[b2[1:0]], 1'b1)
		`CHK({cmd_busy, step_dir}, {1'b0, steps > 0})
		for (int i = 0; i < (steps < 0 ? -steps : steps); i++) begin
			wait_rise();
			if (i == 0) `CHK(n + 1, motor)
			else `CHK(n, ival)
		end
		n = 0;
		while (int_req !== 1'b1 && n < 5000) begin tick(); n++; end
		`CHK(n >= ival && n <= ival + 3, 1'b1)
		`CHK(dm_u.pos - p0, steps)
		`CHK(drive_seek_busy, 4'h0)
		wr(8'h08);
		rd({3'b001, 2'b00, b2[2:0]});
		tick(2);
		`CHK(int_req, 1'b0)
		rd(t[7:0]);
		if (extended_track_range) rd({t[11:8], 4'h0});
	endtask : seek

	// scan-low-or-equal with one compared byte
	task automatic scan(logic [7:0] d, h, e);
		wr(8'h19);
		repeat (8) wr(8'h00);
		n = 0;
		while (scan_byte_req !== 1'b1 && n < 50) begin tick(); n++; end
		`CHK(scan_byte_req, 1'b1)
		{wr_strobe, wr_data} = {1'b1, h};
		tick();
		wr_strobe = 0;
		{disk_valid, disk_byte} = {1'b1, d};
		tick();
		disk_valid = 0;
		tick(2);
		scan_end = 1;
		tick();
		scan_end = 0;
		tick(3);
		`CHK(scan_status, e)
		`CHK(int_req, 1'b1)
		pulse_rd();
		`CHK(int_req, 1'b0)
	endtask : scan

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// watchdog well past the expected run
	initial begin
		tick(60000);
		fail_count++;
		wrap_up();
	end

	// main sequence
	initial begin
		tick(8);
		rst       = 0;
		ready_cmd = 4'h1;
		n         = 0;
		while (int_req !== 1'b1 && n < 20) begin tick(); n++; end
		`CHK(int_req, 1'b1)
		wr(8'h08);
		rd(8'hc0);
		tick(2);
		`CHK(int_req, 1'b0)
		rd(8'h00);
		wr(8'h08);
		rd(8'h80);
		wr(8'h00);
		rd(8'h80);
		cmd(8'h04, 8'h04);
		rd(8'h7c);
		`CHK({int_req, cmd_busy}, 2'b00)
		cmd(8'h61, 8'h31);
		wr(8'h5a);
		rd(8'h5a);
		cmd(8'h21, 8'h31);
		wr(8'h00);
		rd(8'h5a);
		cmd(8'h21, 8'h35);
		wr(8'hff);
		rd(8'h00);
		`CHK(int_req, 1'b0)
		seek(8'h00, 12'h002, 2'h0, 2, 320, 40);
		seek(8'h00, 12'h004, 2'h3, 2, 160, 40);
		seek(8'h00, 12'h006, 2'h2, 2, 640, 160);
		cmd(8'h61, 8'h34);
		wr(8'h01);
		rd(8'h01);
		extended_track_range = 1;
		seek(8'h00, 12'h108, 2'h0, 2, 320, 40);
		seek(8'h04, 12'h107, 2'h0, -1, 320, 40);
		extended_track_range = 0;
		scan(8'h10, 8'h10, 8'h08);
		scan(8'h20, 8'h10, 8'h04);
		scan(8'h08, 8'h10, 8'h00);
		for (int k = 0; k < 2; k++) begin
			{result_entry, nondma_xfer} = k ? 2'b01 : 2'b10;
			tick();
			{result_entry, nondma_xfer} = 2'b00;
			tick(2);
			`CHK(int_req, 1'b1)
			pulse_rd();
			`CHK(int_req, 1'b0)
		end
		soft_reset = 1;
		tick();
		soft_reset = 0;
		cmd(8'h21, 8'h31);
		wr(8'h00);
		rd(8'h00);
		`CHK(int_req, 1'b1)
		wrap_up();
	end
endmodule : fdc_seek_sense_settrack_cmds_test
`default_nettype wire
